// ===== shared/mosd_params.svh
`ifndef MOSD_PARAMS_SVH
`define MOSD_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define MOSD_OFF_WRITE_PROTECT 8'h00
`define MOSD_OFF_OSC_STOP_CTRL 8'h04
`define MOSD_OFF_CLOCK_MODE0 8'h08
`define MOSD_OFF_CLOCK_MODE1 8'h0c
`define MOSD_OFF_FAST_OSC0 8'h10
`define MOSD_OFF_FAST_OSC1 8'h14
`define MOSD_OFF_FAST_OSC2 8'h18
`define MOSD_OFF_VMON2_CTRL 8'h1c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MOSD_BIT_CLK_REG_UNLOCK 0
`define MOSD_BIT_DETECT_EN_LO 0
`define MOSD_BIT_DETECT_EN_HI 1
`define MOSD_BIT_FALLBACK_SEL 2
`define MOSD_BIT_STOPPED_FLAG 3
`define MOSD_BIT_PERIPH_WAIT_STOP 2
`define MOSD_BIT_MAIN_CLK_STOP 5
`define MOSD_BIT_LOW_OSC_DISABLE 4
`define MOSD_BIT_FAST_OSC_SELECT 1
`define MOSD_BIT_VMON2_CAUSE 2
`define MOSD_BIT_WATCHDOG_CAUSE 3

// ------------------------------------------------------------
// values and reset values
// ------------------------------------------------------------
`define MOSD_DETECT_ON 2'b11
`define MOSD_DETECT_OFF 2'b00
`define MOSD_RST_CLOCK_MODE0 8'h00
`define MOSD_RST_CLOCK_MODE1 8'h00
`define MOSD_RST_FAST_OSC 8'h00
`define MOSD_AXI_OKAY 2'b00
`define MOSD_AXI_SLVERR 2'b10

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MOSD_CLK_PERIOD_PS 8000
// period of the slowest main clock that detection must serve (2 mhz)
`define MOSD_MIN_OSC_PERIOD_NS 500

`endif

// ===== shared/mosd_pkg.sv
`default_nettype none

package mosd_pkg;

   typedef enum {MOSD_MON_RUN, MOSD_MON_STOPPED} mosd_mon_state_t;

   // clock steering levels handed to the clock selection logic
   typedef struct packed {
      logic fallback_select;
      logic low_osc_disable;
      logic main_clk_stop_ctrl;
      logic periph_clk_wait_stop;
      logic fast_osc_select;
   } mosd_clk_ctrl_t;

   // stop detection control register content
   typedef struct packed {
      logic main_clk_stopped_flag;
      logic clk_fallback_select;
      logic [1:0] stop_detect_enable_field;
   } mosd_osc_stop_ctrl_t;

endpackage : mosd_pkg

`default_nettype wire

// ===== hw/mosd_osc_monitor.sv
`timescale 1ns/100ps
`default_nettype none

`include "mosd_params.svh"

module mosd_osc_monitor #(
   parameter int STOP_CYCLES = 63
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // oscillator
   input wire logic main_osc_input,
   // status
   output logic osc_stopped,
   output logic stop_pulse,
   output logic run_pulse
);

   localparam int CNT_W = $clog2(STOP_CYCLES + 1);

   generate
      if (STOP_CYCLES < 2)
      begin : g_bad_stop
         $error("stop window must be at least two cycles");
      end
   endgenerate

   mosd_pkg::mosd_mon_state_t state;
   mosd_pkg::mosd_mon_state_t next_state;
   logic sample;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic next_stop_pulse;
   logic next_run_pulse;
   logic edge_seen;

   always_comb
   begin
      edge_seen = (main_osc_input != sample);
      next_state = state;
      next_stop_pulse = 1'b0;
      next_run_pulse = 1'b0;
      next_count = count;
      if (edge_seen)
      begin
         next_count = '0;
      end
      else if (count != CNT_W'(STOP_CYCLES))
      begin
         next_count = count + 1'b1;
      end
      unique case (state)
         mosd_pkg::MOSD_MON_RUN:
         begin
            // a full slowest period with no edge means the oscillator is gone
            if (!edge_seen && count == CNT_W'(STOP_CYCLES - 1))
            begin
               next_state = mosd_pkg::MOSD_MON_STOPPED;
               next_stop_pulse = 1'b1;
            end
         end
         mosd_pkg::MOSD_MON_STOPPED:
         begin
            if (edge_seen)
            begin
               next_state = mosd_pkg::MOSD_MON_RUN;
               next_run_pulse = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= mosd_pkg::MOSD_MON_RUN;
         sample <= 1'b0;
         count <= '0;
         stop_pulse <= 1'b0;
         run_pulse <= 1'b0;
      end
      else
      begin
         state <= next_state;
         sample <= main_osc_input;
         count <= next_count;
         stop_pulse <= next_stop_pulse;
         run_pulse <= next_run_pulse;
      end
   end

   assign osc_stopped = (state == mosd_pkg::MOSD_MON_STOPPED);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_stop_after_window:
      assert property (state == mosd_pkg::MOSD_MON_RUN && !edge_seen && count == CNT_W'(STOP_CYCLES - 1)
                       |=> stop_pulse && osc_stopped)
      else $error("silent oscillator not reported as stopped");

endmodule : mosd_osc_monitor

`default_nettype wire

// ===== hw/mosd_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "mosd_params.svh"


module mosd_top #(
   parameter int ADDR_W = 8,
   parameter int STOP_CYCLES = (`MOSD_MIN_OSC_PERIOD_NS * 1000 + `MOSD_CLK_PERIOD_PS - 1) / `MOSD_CLK_PERIOD_PS
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // oscillator and clock selection
   input wire logic main_osc_input,
   input wire logic cpu_on_main_clk,
   output mosd_pkg::mosd_clk_ctrl_t clk_ctrl,
   // interrupt sources and requests
   input wire logic watchdog_evt,
   input wire logic vmon2_evt,
   output logic osc_stop_nmi,
   output logic shared_nmi_req
);

   generate
      // the unmapped check reads the bits above bit 4, so at least one must exist
      if (ADDR_W < 6 || ADDR_W > 32)
      begin : g_bad_addr
         $error("address width must be 6 to 32 bits");
      end
   endgenerate

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic clk_reg_unlock;
   logic next_clk_reg_unlock;
   mosd_pkg::mosd_osc_stop_ctrl_t osc_stop_ctrl;
   mosd_pkg::mosd_osc_stop_ctrl_t next_osc_stop_ctrl;
   logic [7:0] clock_mode_reg0;
   logic [7:0] next_clock_mode_reg0;
   logic [7:0] clock_mode_reg1;
   logic [7:0] next_clock_mode_reg1;
   logic [7:0] fast_osc_ctrl [0:2];
   logic [7:0] next_fast_osc_ctrl [0:2];
   logic watchdog_cause_flag;
   logic next_watchdog_cause_flag;
   logic vmon2_cause_flag;
   logic next_vmon2_cause_flag;
   logic next_osc_stop_nmi;
   logic next_shared_nmi_req;

   logic aw_held;
   logic next_aw_held;
   logic w_held;
   logic next_w_held;
   logic [ADDR_W-1:0] wr_addr;
   logic [ADDR_W-1:0] next_wr_addr;
   logic [7:0] wr_byte;
   logic [7:0] next_wr_byte;
   logic wr_lane;
   logic next_wr_lane;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   logic do_write;
   logic wr_mapped;
   logic wr_protected;
   logic wr_allowed;
   logic rd_mapped;
   logic [7:0] rd_byte;
   logic stop_evt;
   logic mon_stop_pulse;
   logic mon_run_pulse;
   logic mon_stopped;

   mosd_osc_monitor #(
      .STOP_CYCLES(STOP_CYCLES)
   ) mosd_osc_monitor_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .main_osc_input(main_osc_input),
      .osc_stopped(mon_stopped),
      .stop_pulse(mon_stop_pulse),
      .run_pulse(mon_run_pulse)
   );

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] off;
      off = 8'(a);
      is_mapped = (a[ADDR_W-1:5] == '0) && (off[1:0] == 2'b00);
   endfunction : is_mapped

   function automatic logic is_protected(input logic [ADDR_W-1:0] a);
      logic [7:0] off;
      off = 8'(a);
      is_protected = (off != `MOSD_OFF_WRITE_PROTECT) && (off != `MOSD_OFF_VMON2_CTRL);
   endfunction : is_protected

   // ------------------------------------------------------------
   // register and bus next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wr_addr = wr_addr;
      next_wr_byte = wr_byte;
      next_wr_lane = wr_lane;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_arready = arready;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      next_clk_reg_unlock = clk_reg_unlock;
      next_osc_stop_ctrl = osc_stop_ctrl;
      next_clock_mode_reg0 = clock_mode_reg0;
      next_clock_mode_reg1 = clock_mode_reg1;
      for (int i = 0; i < 3; i++)
      begin
         next_fast_osc_ctrl[i] = fast_osc_ctrl[i];
      end
      next_watchdog_cause_flag = watchdog_cause_flag;
      next_vmon2_cause_flag = vmon2_cause_flag;

      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_wr_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_held = 1'b1;
         next_wr_byte = wdata[7:0];
         next_wr_lane = wstrb[0];
      end

      do_write = aw_held && w_held && !bvalid;
      wr_mapped = is_mapped(wr_addr);
      wr_protected = is_protected(wr_addr);
      // locked clock registers still answer okay, the write just drops
      // locked writes dropped
      wr_allowed = do_write && wr_mapped && wr_lane && (!wr_protected || clk_reg_unlock);

      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_mapped ? `MOSD_AXI_OKAY : `MOSD_AXI_SLVERR;
      end
      else if (bvalid && bready)
      begin
         next_bvalid = 1'b0;
      end

      if (wr_allowed)
      begin
         unique case (8'(wr_addr))
            `MOSD_OFF_WRITE_PROTECT: next_clk_reg_unlock = wr_byte[`MOSD_BIT_CLK_REG_UNLOCK];
            `MOSD_OFF_OSC_STOP_CTRL:
            begin
               next_osc_stop_ctrl.stop_detect_enable_field =
                  wr_byte[`MOSD_BIT_DETECT_EN_HI:`MOSD_BIT_DETECT_EN_LO];
               next_osc_stop_ctrl.clk_fallback_select = wr_byte[`MOSD_BIT_FALLBACK_SEL];
            end
            `MOSD_OFF_CLOCK_MODE0: next_clock_mode_reg0 = wr_byte;
            `MOSD_OFF_CLOCK_MODE1: next_clock_mode_reg1 = wr_byte;
            `MOSD_OFF_FAST_OSC0: next_fast_osc_ctrl[0] = wr_byte;
            `MOSD_OFF_FAST_OSC1: next_fast_osc_ctrl[1] = wr_byte;
            `MOSD_OFF_FAST_OSC2: next_fast_osc_ctrl[2] = wr_byte;
            `MOSD_OFF_VMON2_CTRL:
            begin
               // software clears causes by writing zero; ones are ignored
               next_watchdog_cause_flag = watchdog_cause_flag & wr_byte[`MOSD_BIT_WATCHDOG_CAUSE];
               next_vmon2_cause_flag = vmon2_cause_flag & wr_byte[`MOSD_BIT_VMON2_CAUSE];
            end
            default: ;
         endcase
      end

      // detection only when enabled with main clock driving the cpu
      stop_evt = mon_stop_pulse && cpu_on_main_clk && !osc_stop_ctrl.clk_fallback_select &&
                 (osc_stop_ctrl.stop_detect_enable_field == `MOSD_DETECT_ON);

      // stopped flag follows the oscillator back once it resumes
      if (mon_run_pulse)
      begin
         next_osc_stop_ctrl.main_clk_stopped_flag = 1'b0;
      end
      // hardware set beats any same-cycle software write
      if (stop_evt)
      begin
         next_osc_stop_ctrl.clk_fallback_select = 1'b1;
         next_osc_stop_ctrl.main_clk_stopped_flag = 1'b1;
         next_clock_mode_reg1[`MOSD_BIT_LOW_OSC_DISABLE] = 1'b0;
      end
      if (watchdog_evt)
      begin
         next_watchdog_cause_flag = 1'b1;
      end
      if (vmon2_evt)
      begin
         next_vmon2_cause_flag = 1'b1;
      end

      next_osc_stop_nmi = stop_evt;
      next_shared_nmi_req = stop_evt || watchdog_evt || vmon2_evt;

      rd_mapped = is_mapped(araddr);
      rd_byte = 8'h00;
      unique case (8'(araddr))
         `MOSD_OFF_WRITE_PROTECT: rd_byte[`MOSD_BIT_CLK_REG_UNLOCK] = clk_reg_unlock;
         `MOSD_OFF_OSC_STOP_CTRL: rd_byte[3:0] = osc_stop_ctrl;
         `MOSD_OFF_CLOCK_MODE0: rd_byte = clock_mode_reg0;
         `MOSD_OFF_CLOCK_MODE1: rd_byte = clock_mode_reg1;
         `MOSD_OFF_FAST_OSC0: rd_byte = fast_osc_ctrl[0];
         `MOSD_OFF_FAST_OSC1: rd_byte = fast_osc_ctrl[1];
         `MOSD_OFF_FAST_OSC2: rd_byte = fast_osc_ctrl[2];
         `MOSD_OFF_VMON2_CTRL:
         begin
            rd_byte[`MOSD_BIT_WATCHDOG_CAUSE] = watchdog_cause_flag;
            rd_byte[`MOSD_BIT_VMON2_CAUSE] = vmon2_cause_flag;
         end
         default: rd_byte = 8'h00;
      endcase
      if (arvalid && arready)
      begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rdata = rd_mapped ? {24'h000000, rd_byte} : 32'h00000000;
         next_rresp = rd_mapped ? `MOSD_AXI_OKAY : `MOSD_AXI_SLVERR;
      end
      else if (rvalid && rready)
      begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      else if (!rvalid && !arready)
      begin
         // arready comes up the cycle after reset releases
         next_arready = 1'b1;
      end

      // one write in flight: channels reopen only after the response is taken
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= '0;
         wr_byte <= 8'h00;
         wr_lane <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `MOSD_AXI_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `MOSD_AXI_OKAY;
         clk_reg_unlock <= 1'b0;
         osc_stop_ctrl <= '0;
         clock_mode_reg0 <= `MOSD_RST_CLOCK_MODE0;
         clock_mode_reg1 <= `MOSD_RST_CLOCK_MODE1;
         for (int i = 0; i < 3; i++)
         begin
            fast_osc_ctrl[i] <= `MOSD_RST_FAST_OSC;
         end
         watchdog_cause_flag <= 1'b0;
         vmon2_cause_flag <= 1'b0;
         osc_stop_nmi <= 1'b0;
         shared_nmi_req <= 1'b0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wr_addr <= next_wr_addr;
         wr_byte <= next_wr_byte;
         wr_lane <= next_wr_lane;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         clk_reg_unlock <= next_clk_reg_unlock;
         osc_stop_ctrl <= next_osc_stop_ctrl;
         clock_mode_reg0 <= next_clock_mode_reg0;
         clock_mode_reg1 <= next_clock_mode_reg1;
         for (int i = 0; i < 3; i++)
         begin
            fast_osc_ctrl[i] <= next_fast_osc_ctrl[i];
         end
         watchdog_cause_flag <= next_watchdog_cause_flag;
         vmon2_cause_flag <= next_vmon2_cause_flag;
         osc_stop_nmi <= next_osc_stop_nmi;
         shared_nmi_req <= next_shared_nmi_req;
      end
   end

   assign clk_ctrl.fallback_select = osc_stop_ctrl.clk_fallback_select;
   assign clk_ctrl.low_osc_disable = clock_mode_reg1[`MOSD_BIT_LOW_OSC_DISABLE];
   assign clk_ctrl.main_clk_stop_ctrl = clock_mode_reg0[`MOSD_BIT_MAIN_CLK_STOP];
   assign clk_ctrl.periph_clk_wait_stop = clock_mode_reg0[`MOSD_BIT_PERIPH_WAIT_STOP];
   assign clk_ctrl.fast_osc_select = fast_osc_ctrl[0][`MOSD_BIT_FAST_OSC_SELECT];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_detect_needs_enable:
      assert property (osc_stop_nmi |-> $past(osc_stop_ctrl.stop_detect_enable_field) == 2'b11
                       && $past(cpu_on_main_clk))
      else $error("stop request without detection enabled");
   a_fallback_on_stop:
      assert property (stop_evt |=> clk_ctrl.fallback_select [*2])
      else $error("fallback select not set after stop");
   a_flag_on_stop:
      assert property (stop_evt |=> osc_stop_ctrl.main_clk_stopped_flag)
      else $error("stopped flag not set after stop");
   a_low_osc_runs:
      assert property (stop_evt |=> !clk_ctrl.low_osc_disable)
      else $error("low-speed oscillator left disabled after stop");
   a_stop_nmi_pulse:
      assert property (stop_evt |=> osc_stop_nmi ##1 !osc_stop_nmi)
      else $error("stop request not a single pulse");
   a_nmi_ungated:
      assert property (mon_stop_pulse && cpu_on_main_clk && !osc_stop_ctrl.clk_fallback_select
                       && osc_stop_ctrl.stop_detect_enable_field == 2'b11 |=> shared_nmi_req)
      else $error("stop did not reach the shared request");
   a_shared_vector:
      assert property ((watchdog_evt || vmon2_evt) |=> shared_nmi_req && !osc_stop_nmi || $past(stop_evt))
      else $error("shared request missing for watchdog or vmon2");
   a_watchdog_cause:
      assert property (watchdog_evt |=> watchdog_cause_flag && shared_nmi_req)
      else $error("watchdog cause flag not set");
   a_unlock_write:
      assert property (do_write && wr_lane && 8'(wr_addr) == `MOSD_OFF_CLOCK_MODE0 && clk_reg_unlock
                       && wr_addr[ADDR_W-1:5] == '0 |=> clock_mode_reg0 == $past(wr_byte))
      else $error("unlocked write to clock mode register lost");
   a_locked_drop:
      assert property (do_write && !clk_reg_unlock && 8'(wr_addr) == `MOSD_OFF_CLOCK_MODE0
                       |=> $stable(clock_mode_reg0))
      else $error("locked write changed clock mode register");

   c_stop_detected: cover property (stop_evt ##1 osc_stop_nmi);
   c_locked_write: cover property (do_write && wr_protected && !clk_reg_unlock);
   c_recover: cover property (osc_stop_ctrl.main_clk_stopped_flag ##[1:200] mon_run_pulse);
   c_read_back: cover property (rvalid && rready && rdata != 32'h00000000);

endmodule : mosd_top

`default_nettype wire

// ===== verification/mosd_osc_model.sv
`timescale 1ns/100ps
`default_nettype none

module mosd_osc_model (
   // clock
   input wire logic aclk,
   // bench control
   input wire logic run,
   input wire logic fallback,
   // oscillator and clock selection
   output logic main_osc_input,
   output logic cpu_on_main_clk
);
   logic level = 1'b0;
   // half period of one cycle, far above 2 mhz
   // a stopped crystal simply holds its last level
   always @(posedge aclk)
   begin
      if (run)
         level <= ~level;
   end
   assign main_osc_input = level;
   // main clock drives the cpu again only once fallback is cleared
   assign cpu_on_main_clk = ~fallback;
endmodule : mosd_osc_model

`default_nettype wire

// ===== verification/main_osc_stop_detector_test.sv
`timescale 1ns/100ps
`default_nettype none

module main_osc_stop_detector_test;
   localparam logic [1:0] OK = 2'b00;
   localparam logic [1:0] SE = 2'b10;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b1, watchdog_evt = 1'b0, vmon2_evt = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, osc_stop_nmi, shared_nmi_req, osc, on_main;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   mosd_pkg::mosd_clk_ctrl_t clk_ctrl;
   int errors = 0;
   int cmp_count = 0;

   always #4 aclk = ~aclk;

   mosd_top #(.ADDR_W(8), .STOP_CYCLES(4)) mosd_top_inst (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .main_osc_input(osc), .cpu_on_main_clk(on_main), .clk_ctrl(clk_ctrl),
      .watchdog_evt(watchdog_evt), .vmon2_evt(vmon2_evt),
      .osc_stop_nmi(osc_stop_nmi), .shared_nmi_req(shared_nmi_req));

   mosd_osc_model mosd_osc_model_inst (.aclk(aclk), .run(run), .fallback(clk_ctrl.fallback_select),
      .main_osc_input(osc), .cpu_on_main_clk(on_main));

   // ------------------------------
   // bus and compare tasks
   // ------------------------------
   task automatic report_and_stop;
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, r});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, r});
   endtask : rd

   // stops the crystal and watches for the stop request
   task automatic stop_wait(input logic e);
      logic seen;
      seen = 1'b0;
      run <= 1'b0;
      repeat (40)
      begin
         @(posedge aclk);
         if (osc_stop_nmi === 1'b1)
         begin
            seen = 1'b1;
            chk({31'h0, shared_nmi_req}, 32'h1);
         end
      end
      chk({31'h0, seen}, {31'h0, e});
   endtask : stop_wait

   task automatic pulse(input logic w);
      @(posedge aclk);
      watchdog_evt <= w;
      vmon2_evt <= ~w;
      @(posedge aclk);
      watchdog_evt <= 1'b0;
      vmon2_evt <= 1'b0;
      @(posedge aclk);
      chk({31'h0, shared_nmi_req}, 32'h1);
   endtask : pulse

   // ------------------------------
   // tests
   // ------------------------------
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h04, 32'h0, OK);
      wr(8'h04, 32'h3, OK);
      rd(8'h04, 32'h0, OK);
      wr(8'h00, 32'h1, OK);
      wr(8'h0c, 32'h10, OK);
      chk({27'h0, clk_ctrl}, 32'h08);
      wr(8'h04, 32'h2, OK);
      stop_wait(1'b0);
      run <= 1'b1;
      repeat (4) @(posedge aclk);
      wr(8'h04, 32'h3, OK);
      stop_wait(1'b1);
      chk({27'h0, clk_ctrl}, 32'h10);
      rd(8'h04, 32'hf, OK);
      run <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(8'h04, 32'h7, OK);
      wr(8'h04, 32'h0, OK);
      wr(8'h08, 32'h24, OK);
      wr(8'h10, 32'h2, OK);
      chk({27'h0, clk_ctrl}, 32'h07);
      wr(8'h00, 32'h0, OK);
      wr(8'h08, 32'h0, OK);
      chk({27'h0, clk_ctrl}, 32'h07);
      pulse(1'b1);
      rd(8'h1c, 32'h08, OK);
      pulse(1'b0);
      rd(8'h1c, 32'h0c, OK);
      wr(8'h1c, 32'h0, OK);
      rd(8'h1c, 32'h0, OK);
      rd(8'h20, 32'h0, SE);
      wr(8'h22, 32'h1, SE);
      report_and_stop();
   end

   // tests need well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      errors++;
      report_and_stop();
   end
endmodule : main_osc_stop_detector_test

`default_nettype wire
